// *** hdl/rpl_top.sv ***
// receive port counters and back channel configuration, all ports
`timescale 1ns/1ps
`default_nettype none
`include "rpl_params.svh"
// Contract
// - each port counts parity errors, low byte readable
// - count restarts on valid lock or low read
// - low byte read returns value, then clears
// - low byte read also clears high byte
// - per-port read-only self-test error count byte
// - port select chooses accessed port's registers
// - forward-all bit forwards every local transaction
// - forward-on-match bit forwards only decoded transactions
// - ack-every-write bit acknowledges all writes locally
// - force-on keeps back channel enabled always
// - otherwise back channel needs a forwarding bit
// - force-on bit writable only by local controller
// - bit 3 enables back channel CRC generation
// - rate field loaded from strap, three valid codes
// - remote rate change first forces auto acknowledge
module rpl_top
   import rpl_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire rpl_reg_req_type i_req,
   input wire logic [`RPL_NUM_PORTS-1:0] i_par_err,
   input wire logic [`RPL_NUM_PORTS-1:0] i_lock_valid,
   input wire logic [`RPL_NUM_PORTS-1:0][7:0] i_bist_count,
   input wire logic [2:0] i_rate_strap,
   output rpl_bcc_ctrl_type [`RPL_NUM_PORTS-1:0] o_ctrl,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid
);
   logic [`RPL_SEL_W-1:0] sel_reg;
   logic [7:0] rdata_reg;
   logic rvalid_reg;
   logic [7:0] rdata_next;
   logic hit_sel;
   logic hit_hi;
   logic hit_lo;
   logic hit_bist;
   logic hit_bcc;
   logic rd_lo;
   logic wr_bcc;
   logic [`RPL_NUM_PORTS-1:0][15:0] count_w;
   logic [`RPL_NUM_PORTS-1:0][7:0] cfg_w;
   rpl_bcc_ctrl_type [`RPL_NUM_PORTS-1:0] ctrl_w;

   // ==========================================
   // address decode
   assign hit_sel = (i_req.addr == `RPL_ADDR_PORT_SEL);
   assign hit_hi = (i_req.addr == `RPL_ADDR_PAR_HI);
   assign hit_lo = (i_req.addr == `RPL_ADDR_PAR_LO);
   assign hit_bist = (i_req.addr == `RPL_ADDR_BIST);
   assign hit_bcc = (i_req.addr == `RPL_ADDR_BCC);
   assign rd_lo = i_req.rd && hit_lo;
   assign wr_bcc = i_req.wr && hit_bcc;

   // port select register
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         sel_reg <= `RPL_RST_PORT_SEL;
      end else if (i_req.wr && hit_sel) begin
         sel_reg <= i_req.wdata[`RPL_SEL_W-1:0];
      end
   end

   // ==========================================
   // per-port counters and configuration
   generate
      for (genvar p = 0; p < `RPL_NUM_PORTS; p++) begin : g_port
         logic is_sel;
         assign is_sel = (sel_reg == `RPL_SEL_W'(p));
         rpl_par_counter u_cnt (
            .i_clk(i_clk),
            .i_reset_n(i_reset_n),
            .i_par_err(i_par_err[p]),
            .i_lock_valid(i_lock_valid[p]),
            .i_clr_rd(rd_lo && is_sel),
            .o_count(count_w[p])
         );
         rpl_bcc_cfg u_cfg (
            .i_clk(i_clk),
            .i_reset_n(i_reset_n),
            .i_wr(wr_bcc && is_sel),
            .i_remote(i_req.remote),
            .i_wdata(i_req.wdata),
            .i_rate_strap(i_rate_strap),
            .o_ctrl(ctrl_w[p]),
            .o_cfg_byte(cfg_w[p])
         );
      end
   endgenerate

   // ==========================================
   // read back of the selected port, unmapped reads as zero
   assign rdata_next = hit_sel ? {6'h00, sel_reg} :
                       hit_hi ? count_w[sel_reg][15:8] :
                       hit_lo ? count_w[sel_reg][7:0] :
                       hit_bist ? i_bist_count[sel_reg] :
                       hit_bcc ? cfg_w[sel_reg] : 8'h00;

   // read data register, one cycle after the read strobe
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= i_req.rd;
         if (i_req.rd) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   assign o_reg_rdata = rdata_reg;
   assign o_reg_rvalid = rvalid_reg;
   assign o_ctrl = ctrl_w;

   // ==========================================
   // assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   rd_low_a: assert property (
      rd_lo |=> o_reg_rvalid && o_reg_rdata == $past(count_w[sel_reg][7:0]))
      else $error("low byte read data wrong");

   lock_restart_a: assert property (
      i_lock_valid[sel_reg] && !i_par_err[sel_reg]
      |=> count_w[$past(sel_reg)] == 16'h0000)
      else $error("lock did not restart count");

   rd_clear_a: assert property (
      rd_lo && !i_par_err[sel_reg] |=> count_w[$past(sel_reg)] == 16'h0000)
      else $error("low read did not clear count");

   hi_keep_a: assert property (
      i_req.rd && hit_hi && !i_par_err[sel_reg] && !i_lock_valid[sel_reg]
      |=> count_w[$past(sel_reg)] == $past(count_w[sel_reg]))
      else $error("high read changed count");

   bist_read_a: assert property (
      i_req.rd && hit_bist |=> o_reg_rdata == $past(i_bist_count[sel_reg]))
      else $error("self-test count read wrong");

   cfg_write_a: assert property (
      wr_bcc && !i_req.remote |=> cfg_w[$past(sel_reg)][7:3] ==
      $past(i_req.wdata[7:3]))
      else $error("local config write lost");

   bc_off_a: assert property (
      wr_bcc && !i_req.remote && i_req.wdata[7:4] == 4'h0
      |=> !o_ctrl[$past(sel_reg)].bc_enable)
      else $error("back channel on without cause");

   bc_force_a: assert property (
      o_ctrl[0].force_on |-> o_ctrl[0].bc_enable)
      else $error("force-on did not enable back channel");

   force_remote_a: assert property (
      wr_bcc && i_req.remote
      |=> o_ctrl[$past(sel_reg)].force_on == $past(o_ctrl[sel_reg].force_on))
      else $error("remote write changed force-on");

   rate_ack_a: assert property (
      wr_bcc && i_req.remote && rpl_rate_ok(i_req.wdata[2:0]) &&
      i_req.wdata[2:0] != o_ctrl[sel_reg].rate
      |=> o_ctrl[$past(sel_reg)].auto_ack &&
      o_ctrl[$past(sel_reg)].rate == $past(o_ctrl[sel_reg].rate) ##1
      o_ctrl[$past(sel_reg, 2)].rate == $past(i_req.wdata[2:0], 2))
      else $error("remote rate change without auto ack first");

   strap_load_a: assert property (
      $rose(i_reset_n) |-> o_ctrl[0].rate == $past(i_rate_strap))
      else $error("rate not taken from strap");

   sat_hold_a: assert property (
      count_w[sel_reg] == 16'hFFFF && !i_lock_valid[sel_reg] && !rd_lo
      |=> count_w[$past(sel_reg)] == 16'hFFFF)
      else $error("counter wrapped");

   rd_count_c: cover property (rd_lo && count_w[sel_reg] != 16'h0000);
   sat_c: cover property (count_w[sel_reg] == 16'hFFFF &&
      i_par_err[sel_reg]);
   remote_rate_c: cover property (wr_bcc && i_req.remote ##2
      $changed(o_ctrl[sel_reg].rate));
   bc_off_c: cover property (!o_ctrl[sel_reg].bc_enable);
endmodule
`default_nettype wire

// *** hdl/rpl_params.svh ***
// offsets, field positions, reset values and codes of the receive port registers
`ifndef RPL_PARAMS_SVH
`define RPL_PARAMS_SVH
// ==========================================
// sizes
`define RPL_NUM_PORTS 4
`define RPL_SEL_W 2
// ==========================================
// register offsets
`define RPL_ADDR_PORT_SEL 8'h4C
`define RPL_ADDR_PAR_HI 8'h55
`define RPL_ADDR_PAR_LO 8'h56
`define RPL_ADDR_BIST 8'h57
`define RPL_ADDR_BCC 8'h58
// ==========================================
// back channel config field positions
`define RPL_BIT_PASS_ALL 7
`define RPL_BIT_PASS_MATCH 6
`define RPL_BIT_AUTO_ACK 5
`define RPL_BIT_FORCE_ON 4
`define RPL_BIT_CRC_EN 3
`define RPL_RATE_MSB 2
`define RPL_RATE_LSB 0
// ==========================================
// reset values and counter limit
`define RPL_RST_PASS_ALL 1'b0
`define RPL_RST_PASS_MATCH 1'b0
`define RPL_RST_AUTO_ACK 1'b0
`define RPL_RST_FORCE_ON 1'b1
`define RPL_RST_CRC_EN 1'b1
`define RPL_RST_PORT_SEL 2'h0
`define RPL_RST_COUNT 16'h0000
`define RPL_COUNT_MAX 16'hFFFF
// ==========================================
// return link rate codes
`define RPL_RATE_2M5 3'h0
`define RPL_RATE_10M 3'h2
`define RPL_RATE_50M 3'h6
`endif

// *** hdl/rpl_pkg.sv ***
// types shared by the receive port register logic
`default_nettype none
`include "rpl_params.svh"
package rpl_pkg;
   // one register access from the local target port decoder
   typedef struct packed {
      logic wr;
      logic rd;
      logic remote;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rpl_reg_req_type;

   // per-port back channel controls
   typedef struct packed {
      logic pass_all;
      logic pass_match;
      logic auto_ack;
      logic force_on;
      logic crc_en;
      logic [2:0] rate;
      logic bc_enable;
   } rpl_bcc_ctrl_type;

   // only the three documented rate codes are accepted
   function automatic logic rpl_rate_ok(input logic [2:0] code);
      rpl_rate_ok = (code == `RPL_RATE_2M5) || (code == `RPL_RATE_10M) ||
                    (code == `RPL_RATE_50M);
   endfunction
endpackage
`default_nettype wire

// *** hdl/rpl_par_counter.sv ***
// saturating parity error counter with read and lock restart
`timescale 1ns/1ps
`default_nettype none
`include "rpl_params.svh"
module rpl_par_counter
   import rpl_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_par_err,
   input wire logic i_lock_valid,
   input wire logic i_clr_rd,
   output logic [15:0] o_count
);
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic restart;
   logic at_max;

   // ==========================================
   // next count
   // restart on lock or low byte read; an error in the same cycle counts
   assign restart = i_lock_valid | i_clr_rd;
   assign at_max = (count_reg == `RPL_COUNT_MAX);
   assign count_next = restart ? {15'h0000, i_par_err} :
                       (i_par_err && !at_max) ? count_reg + 16'h0001 :
                       count_reg;

   // counter register
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         count_reg <= `RPL_RST_COUNT;
      end else begin
         count_reg <= count_next;
      end
   end

   assign o_count = count_reg;
endmodule
`default_nettype wire

// *** hdl/rpl_bcc_cfg.sv ***
// per-port back channel configuration byte
`timescale 1ns/1ps
`default_nettype none
`include "rpl_params.svh"
module rpl_bcc_cfg
   import rpl_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_wr,
   input wire logic i_remote,
   input wire logic [7:0] i_wdata,
   input wire logic [2:0] i_rate_strap,
   output rpl_bcc_ctrl_type o_ctrl,
   output logic [7:0] o_cfg_byte
);
   logic pass_all_reg;
   logic pass_match_reg;
   logic auto_ack_reg;
   logic force_on_reg;
   logic crc_en_reg;
   logic [2:0] rate_reg;
   logic pend_reg;
   logic [2:0] pend_rate_reg;
   logic [2:0] new_rate;
   logic rate_ok;
   logic remote_chg;
   logic local_rate;

   // ==========================================
   // write decode
   assign new_rate = i_wdata[`RPL_RATE_MSB:`RPL_RATE_LSB];
   assign rate_ok = i_wr && rpl_rate_ok(new_rate);
   // a remote rate change is deferred one cycle behind auto acknowledge
   assign remote_chg = rate_ok && i_remote && (new_rate != rate_reg);
   assign local_rate = rate_ok && !i_remote;

   // field registers; strap taken while reset is held
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         pass_all_reg <= `RPL_RST_PASS_ALL;
         pass_match_reg <= `RPL_RST_PASS_MATCH;
         auto_ack_reg <= `RPL_RST_AUTO_ACK;
         force_on_reg <= `RPL_RST_FORCE_ON;
         crc_en_reg <= `RPL_RST_CRC_EN;
         rate_reg <= i_rate_strap;
      end else if (i_wr) begin
         pass_all_reg <= i_wdata[`RPL_BIT_PASS_ALL];
         pass_match_reg <= i_wdata[`RPL_BIT_PASS_MATCH];
         auto_ack_reg <= i_wdata[`RPL_BIT_AUTO_ACK] | remote_chg;
         if (!i_remote) begin
            force_on_reg <= i_wdata[`RPL_BIT_FORCE_ON];
         end
         crc_en_reg <= i_wdata[`RPL_BIT_CRC_EN];
      end
      if (i_reset_n && pend_reg) begin
         rate_reg <= pend_rate_reg;
      end else if (i_reset_n && local_rate) begin
         rate_reg <= new_rate;
      end
   end

   // pending remote rate change
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         pend_reg <= 1'b0;
         pend_rate_reg <= `RPL_RATE_2M5;
      end else begin
         pend_reg <= remote_chg;
         pend_rate_reg <= new_rate;
      end
   end

   // ==========================================
   // outputs
   // whole struct in one assignment, one driver for the output
   assign o_ctrl = '{pass_all: pass_all_reg,
                     pass_match: pass_match_reg,
                     auto_ack: auto_ack_reg,
                     force_on: force_on_reg,
                     crc_en: crc_en_reg,
                     rate: rate_reg,
                     bc_enable: force_on_reg | pass_all_reg |
                                pass_match_reg};
   assign o_cfg_byte = {pass_all_reg, pass_match_reg, auto_ack_reg,
                        force_on_reg, crc_en_reg, rate_reg};
endmodule
`default_nettype wire

// *** test/rpl_far_model.sv ***
// far side model: receiver error and lock events, self-test counts
`timescale 1ns/1ps
`default_nettype none
`include "rpl_params.svh"
module rpl_far_model (
   input wire logic i_clk,
   output logic [`RPL_NUM_PORTS-1:0] o_par_err,
   output logic [`RPL_NUM_PORTS-1:0] o_lock_valid,
   output logic [`RPL_NUM_PORTS-1:0][7:0] o_bist_count
);
   // ==========================================
   // idle levels and fixed self-test totals per port
   initial begin
      o_par_err = '0;
      o_lock_valid = '0;
      for (int p = 0; p < `RPL_NUM_PORTS; p++) begin
         o_bist_count[p] = 8'hA0 + 8'(p);
      end
   end

   // error line held high n cycles, one count per high cycle
   task automatic send_errs(input int port, input int n);
      @(negedge i_clk);
      o_par_err[port] = 1'b1;
      repeat (n) @(negedge i_clk);
      o_par_err[port] = 1'b0;
   endtask

   // single cycle lock event
   task automatic pulse_lock(input int port);
      @(negedge i_clk);
      o_lock_valid[port] = 1'b1;
      @(negedge i_clk);
      o_lock_valid[port] = 1'b0;
   endtask
endmodule
`default_nettype wire

// *** test/rpl_top_test.sv ***
// register level test of the receive port counters and config byte
`timescale 1ns/1ps
`default_nettype none
`include "rpl_params.svh"
module rpl_top_test
   import rpl_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   rpl_reg_req_type req = '0;
   logic [2:0] strap = 3'h6;
   logic [`RPL_NUM_PORTS-1:0] par_err;
   logic [`RPL_NUM_PORTS-1:0] lock_valid;
   logic [`RPL_NUM_PORTS-1:0][7:0] bist;
   rpl_bcc_ctrl_type [`RPL_NUM_PORTS-1:0] ctrl;
   logic [7:0] rdata;
   logic [7:0] v;
   logic rvalid;
   logic [2:0] codes [3] = '{3'h0, 3'h2, 3'h6};
   int bad_count = 0;
   int n_tests = 0;

   // ==========================================
   // clock, design and far side
   always #50 i_clk = ~i_clk;

   rpl_top rpl_top_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(req),
      .i_par_err(par_err), .i_lock_valid(lock_valid), .i_bist_count(bist),
      .i_rate_strap(strap), .o_ctrl(ctrl), .o_reg_rdata(rdata),
      .o_reg_rvalid(rvalid));

   rpl_far_model rpl_far_model_i (.i_clk(i_clk), .o_par_err(par_err),
      .o_lock_valid(lock_valid), .o_bist_count(bist));

   // ==========================================
   // compare, report and register access tasks
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one write strobe, held across one rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic rem);
      @(negedge i_clk);
      req = '{wr: 1'b1, rd: 1'b0, remote: rem, addr: a, wdata: d};
      @(negedge i_clk);
      req = '0;
   endtask

   // one read strobe, then bounded wait for the valid pulse
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int k;
      @(negedge i_clk);
      req = '{wr: 1'b0, rd: 1'b1, remote: 1'b0, addr: a, wdata: 8'h00};
      @(negedge i_clk);
      req = '0;
      k = 0;
      while (rvalid !== 1'b1 && k < 4) begin
         @(negedge i_clk);
         k++;
      end
      d = rdata;
      if (rvalid !== 1'b1) begin
         bad_count++;
         print_verdict();
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      rd(a, v);
      chk(v, exp);
   endtask

   // ==========================================
   // main sequence; error events never overlap a read
   initial begin
      repeat (12) @(negedge i_clk);
      i_reset_n = 1'b1;
      // reset values, strap rate 110
      rchk(8'h4C, 8'h00);
      rchk(8'h58, 8'h1E);
      chk(ctrl[0].bc_enable, 1'b1);
      rchk(8'h56, 8'h00);
      // port select steers the self-test count
      for (int p = 0; p < 4; p++) begin
         wr(8'h4C, 8'(p), 1'b0);
         rchk(8'h4C, 8'(p));
         rchk(8'h57, 8'hA0 + 8'(p));
      end
      wr(8'h57, 8'h55, 1'b0);
      rchk(8'h57, 8'hA3);
      rchk(8'h10, 8'h00);
      // separate counts per port, clear on low read
      rpl_far_model_i.send_errs(3, 5);
      rpl_far_model_i.send_errs(1, 3);
      rchk(8'h55, 8'h00);
      rchk(8'h56, 8'h05);
      rchk(8'h56, 8'h00);
      wr(8'h4C, 8'h01, 1'b0);
      rchk(8'h56, 8'h03);
      // high byte survives its own read, cleared by the low read
      rpl_far_model_i.send_errs(1, 300);
      rchk(8'h55, 8'h01);
      rchk(8'h55, 8'h01);
      rchk(8'h56, 8'h2C);
      rchk(8'h55, 8'h00);
      // lock restarts the count
      rpl_far_model_i.send_errs(1, 4);
      rpl_far_model_i.pulse_lock(1);
      rpl_far_model_i.send_errs(1, 2);
      rchk(8'h56, 8'h02);
      // long burst stops at the top
      rpl_far_model_i.send_errs(1, 65540);
      rchk(8'h55, 8'hFF);
      rchk(8'h56, 8'hFF);
      // forwarding bits and back channel enable on port 1
      wr(8'h58, 8'h02, 1'b0);
      chk(ctrl[1].bc_enable, 1'b0);
      chk(ctrl[0].bc_enable, 1'b1);
      wr(8'h58, 8'h80, 1'b0);
      chk({ctrl[1].pass_all, ctrl[1].bc_enable}, 2'b11);
      wr(8'h58, 8'h40, 1'b0);
      chk({ctrl[1].pass_all, ctrl[1].pass_match, ctrl[1].bc_enable},
          3'b011);
      wr(8'h58, 8'h28, 1'b0);
      chk({ctrl[1].auto_ack, ctrl[1].crc_en, ctrl[1].bc_enable},
          3'b110);
      rchk(8'h58, 8'h28);
      wr(8'h58, 8'h10, 1'b0);
      chk(ctrl[1].bc_enable, 1'b1);
      // every valid rate code, then a reserved one
      foreach (codes[i]) begin
         wr(8'h58, {5'h01, codes[i]}, 1'b0);
         chk(ctrl[1].rate, codes[i]);
      end
      wr(8'h58, 8'h0B, 1'b0);
      rchk(8'h58, 8'h0E);
      // remote write: force-on kept, auto ack first, rate next cycle
      wr(8'h58, 8'h12, 1'b1);
      chk({ctrl[1].auto_ack, ctrl[1].rate}, 4'hE);
      rchk(8'h58, 8'h22);
      // second reset with the other strap level reloads the rate
      strap = 3'h0;
      @(negedge i_clk);
      i_reset_n = 1'b0;
      repeat (2) @(negedge i_clk);
      i_reset_n = 1'b1;
      rchk(8'h4C, 8'h00);
      rchk(8'h58, 8'h18);
      print_verdict();
   end
endmodule
`default_nettype wire
